// >>> common/fcsr_consts.svh
`ifndef FCSR_CONSTS_SVH
`define FCSR_CONSTS_SVH
// ----------------------------------------
// Command codes
// ----------------------------------------
`define FCSR_CMD_READ_ARRAY   8'hFF
`define FCSR_CMD_WORD_PGM_A   8'h10
`define FCSR_CMD_WORD_PGM_B   8'h40
`define FCSR_CMD_BUF_PGM      8'hE8
`define FCSR_CMD_ERASE        8'h20
`define FCSR_CMD_BUFFERED_FACTORY_PROGRAM_MODE         8'h30
`define FCSR_CMD_CONFIRM      8'hD0
`define FCSR_CMD_SUSPEND      8'hB0
`define FCSR_CMD_READ_STATUS  8'h70
`define FCSR_CMD_CLEAR_STATUS 8'h50
`define FCSR_CMD_READ_ID      8'h90
`define FCSR_CMD_READ_QUERY   8'h98
`define FCSR_CMD_LOCK_SETUP   8'h60
`define FCSR_CMD_OTP_SETUP    8'hC0
`define FCSR_CMD_LOCK_CONF    8'h01
`define FCSR_CMD_LOCKDN_CONF  8'h2F
`define FCSR_CMD_CR_CONF      8'h03
`define FCSR_CMD_BUFFERED_FACTORY_PROGRAM_MODE_EXIT    16'hFFFF
// ----------------------------------------
// Field positions and reset values
// ----------------------------------------
`define FCSR_STS_BUFFERED_FACTORY_PROGRAM_MODE_BUSY_BIT 0
`define FCSR_ERR_RESET         4'h0
`endif

// >>> common/fcsr_pkg.sv
package fcsr_pkg;
  typedef enum logic [1:0] {
    FCSR_SRC_ARRAY,
    FCSR_SRC_ID,
    FCSR_SRC_QUERY,
    FCSR_SRC_STATUS
  } fcsr_src_e;

  typedef enum logic [3:0] {
    FCSR_READY,
    FCSR_PGM_SETUP,
    FCSR_PGM_BUSY,
    FCSR_PGM_SUSP,
    FCSR_PGM_SUSP_ERASE_SETUP,
    FCSR_ERASE_SETUP,
    FCSR_ERASE_BUSY,
    FCSR_ERASE_SUSP,
    FCSR_LOCK_SETUP,
    FCSR_OTP_SETUP,
    FCSR_OTP_BUSY,
    FCSR_BUFFERED_FACTORY_PROGRAM_MODE_SETUP,
    FCSR_BUFFERED_FACTORY_PROGRAM_MODE_MODE
  } fcsr_state_e;
endpackage : fcsr_pkg

// >>> common/fcsr_sel_if.sv
interface fcsr_sel_if #(parameter int PARTS = 8);
  logic                      wr;
  logic [$clog2(PARTS)-1:0]  part;
  fcsr_pkg::fcsr_src_e       src;
  logic [2*PARTS-1:0]        sel_flat;
  modport ctl (output wr, output part, output src, input sel_flat);
  modport mem (input wr, input part, input src, output sel_flat);
endinterface : fcsr_sel_if

// >>> logic/fcsr_part_sel.sv
module fcsr_part_sel #(
  parameter int PARTS = 8
) (
  input  wire logic  i_ref_clk, // Clock.
  input  wire logic  i_reset,   // Async reset.
  fcsr_sel_if.mem    sel        // Selector update port.
);
  import fcsr_pkg::*;
  typedef struct packed {
    logic [PARTS-1:0][1:0] src;
  } fcsr_sel_s;
  fcsr_sel_s s_q;
  fcsr_sel_s s_d;

  // RQ9 - hold output selection
  always_comb begin
    s_d = s_q;
    if (sel.wr) begin
      s_d.src[sel.part] = sel.src;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign sel.sel_flat = s_q.src;
endmodule : fcsr_part_sel

// >>> logic/fcsr_top.sv
// Function
// RQ1 - Codes outside the allowed command set are treated as illegal; in erase or lock setup they are not flagged and the state returns to ready.
// RQ2 - Array reads from a busy partition return invalid data.
// RQ3 - Identifier and query data come from distinct address locations.
// RQ4 - Host gives both cycles of two-cycle commands same partition.
// RQ5 - In program suspend, erase setup then confirm ignores the confirm.
// RQ6 - Clear status clears error bits only when the engine is idle.
// RQ7 - Factory-program data accepted only while status bit 0 is zero.
// RQ8 - One chip-wide state, independent of partition output selectors.
// RQ9 - Each partition keeps its last output selection for reads.
// RQ10 - Lock, lock-down and configuration confirms operate then return ready.
// RQ11 - First-cycle block address is latched as operation reference.
// RQ12 - Ignored cycles change neither state nor output selections; the ignored RQ5 confirm moves the state back to program suspend.
`include "fcsr_consts.svh"
module fcsr_top #(
  parameter int PARTS  = 8,
  parameter int AW     = 23,
  parameter int BLK_LO = 16
) (
  input  wire logic                    i_ref_clk,    // Clock.
  input  wire logic                    i_reset,      // Async reset, high.
  input  wire logic                    i_wr,         // Command write strobe.
  input  wire logic [AW-1:0]           i_addr,       // Write address.
  input  wire logic [15:0]             i_data,       // Write data.
  input  wire logic                    i_done,       // Embedded operation complete.
  input  wire logic [3:0]              i_err_set,    // Error bits raised by engine.
  input  wire logic [$clog2(PARTS)-1:0] i_rd_part,   // Partition being read.
  input  wire logic                    i_rd_id_loc,  // Read address is in the ID region.
  output fcsr_pkg::fcsr_state_e        o_state,      // Write state machine state.
  output fcsr_pkg::fcsr_src_e          o_rd_src,     // Source for the current read.
  output logic                         o_rd_invalid, // Read data undefined.
  output logic [AW-1:BLK_LO]           o_blk_addr,   // first_cycle_block_address.
  output logic [3:0]                   o_err,        // Status error bits.
  output logic                         o_busy,       // Engine running.
  output logic                         o_buffered_factory_program_mode_data,  // Accepted factory-program word.
  output logic                         o_illegal     // Illegal command pulse.
);
  import fcsr_pkg::*;
  localparam int PW = $clog2(PARTS);

  typedef struct packed {
    fcsr_state_e         st;
    logic [AW-1:BLK_LO]  blk;
    logic [PW-1:0]       busy_part;
    logic [3:0]          err;
    logic                buffered_factory_program_mode_dat;
    logic                illegal;
  } fcsr_top_s;
  fcsr_top_s s_q;
  fcsr_top_s s_d;

  fcsr_sel_if #(.PARTS(PARTS)) sel ();

  fcsr_part_sel #(.PARTS(PARTS)) u_sel (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .sel       (sel)
  );

  // ----------------------------------------
  // Decode helpers
  // ----------------------------------------
  function automatic logic fcsr_is_busy(input fcsr_state_e s);
    return (s == FCSR_PGM_BUSY) || (s == FCSR_ERASE_BUSY) ||
           (s == FCSR_OTP_BUSY) || (s == FCSR_BUFFERED_FACTORY_PROGRAM_MODE_MODE) || (s == FCSR_BUFFERED_FACTORY_PROGRAM_MODE_SETUP);
  endfunction : fcsr_is_busy

  logic [7:0]        cmd;
  logic [PW-1:0]     wpart;
  logic              legal;
  logic              sel_wr;
  fcsr_src_e         sel_src;
  assign cmd   = i_data[7:0];
  assign wpart = i_addr[AW-1 -: PW];

  // RQ1 - allowed set
  always_comb begin
    case (cmd)
      `FCSR_CMD_READ_ARRAY, `FCSR_CMD_WORD_PGM_A, `FCSR_CMD_WORD_PGM_B, `FCSR_CMD_BUF_PGM,
      `FCSR_CMD_ERASE, `FCSR_CMD_BUFFERED_FACTORY_PROGRAM_MODE, `FCSR_CMD_CONFIRM, `FCSR_CMD_SUSPEND,
      `FCSR_CMD_READ_STATUS, `FCSR_CMD_CLEAR_STATUS, `FCSR_CMD_READ_ID, `FCSR_CMD_READ_QUERY,
      `FCSR_CMD_LOCK_SETUP, `FCSR_CMD_OTP_SETUP, `FCSR_CMD_LOCK_CONF, `FCSR_CMD_LOCKDN_CONF,
      `FCSR_CMD_CR_CONF: legal = 1'b1;
      default: legal = 1'b0;
    endcase
  end

  // ----------------------------------------
  // Write state machine
  // ----------------------------------------
  // RQ8 - single chip state
  always_comb begin
    s_d          = s_q;
    s_d.buffered_factory_program_mode_dat = 1'b0;
    s_d.illegal  = 1'b0;
    sel_wr       = 1'b0;
    sel_src      = FCSR_SRC_STATUS;
    if (i_done && fcsr_is_busy(s_q.st) && s_q.st != FCSR_BUFFERED_FACTORY_PROGRAM_MODE_SETUP) begin
      s_d.st = (s_q.st == FCSR_BUFFERED_FACTORY_PROGRAM_MODE_MODE) ? FCSR_BUFFERED_FACTORY_PROGRAM_MODE_MODE : FCSR_READY;
    end
    if (i_done && s_q.st == FCSR_BUFFERED_FACTORY_PROGRAM_MODE_SETUP) begin
      s_d.st = FCSR_BUFFERED_FACTORY_PROGRAM_MODE_MODE;
    end
    if (i_wr) begin
      case (s_q.st)
        FCSR_BUFFERED_FACTORY_PROGRAM_MODE_SETUP, FCSR_BUFFERED_FACTORY_PROGRAM_MODE_MODE: begin
          // RQ7 - data only when bit zero clear
          if (s_q.st == FCSR_BUFFERED_FACTORY_PROGRAM_MODE_MODE && i_data == `FCSR_CMD_BUFFERED_FACTORY_PROGRAM_MODE_EXIT &&
              i_addr[AW-1:BLK_LO] != s_q.blk) begin
            s_d.st = FCSR_READY;
          end else if (s_q.st == FCSR_BUFFERED_FACTORY_PROGRAM_MODE_MODE && !i_done) begin
            s_d.buffered_factory_program_mode_dat = 1'b1;
          end
        end
        FCSR_PGM_BUSY, FCSR_ERASE_BUSY, FCSR_OTP_BUSY: begin
          if (cmd == `FCSR_CMD_SUSPEND && s_q.st != FCSR_OTP_BUSY) begin
            s_d.st = (s_q.st == FCSR_PGM_BUSY) ? FCSR_PGM_SUSP : FCSR_ERASE_SUSP;
          end
          // RQ6 - clear ignored while busy
          if (cmd == `FCSR_CMD_READ_STATUS || cmd == `FCSR_CMD_SUSPEND) begin
            sel_wr = 1'b1;
          end
          // RQ2 - array read while busy
          if (cmd == `FCSR_CMD_READ_ARRAY) begin
            sel_wr  = 1'b1;
            sel_src = FCSR_SRC_ARRAY;
          end
          s_d.illegal = !legal;
        end
        FCSR_PGM_SETUP, FCSR_ERASE_SETUP, FCSR_OTP_SETUP: begin
          sel_wr = 1'b1;
          if (s_q.st == FCSR_ERASE_SETUP) begin
            s_d.st = (cmd == `FCSR_CMD_CONFIRM) ? FCSR_ERASE_BUSY : FCSR_READY;
          end else begin
            s_d.st = (s_q.st == FCSR_PGM_SETUP) ? FCSR_PGM_BUSY : FCSR_OTP_BUSY;
          end
          s_d.busy_part = wpart;
        end
        FCSR_PGM_SUSP_ERASE_SETUP: begin
          // RQ5 - ambiguous confirm ignored
          // RQ12 - state returns to program suspend
          s_d.st = FCSR_PGM_SUSP;
        end
        FCSR_LOCK_SETUP: begin
          // RQ10 - confirm then ready
          sel_wr = 1'b1;
          s_d.st = FCSR_READY;
        end
        default: begin
          if (!legal) begin
            // RQ12 - illegal leaves state
            s_d.illegal = 1'b1;
          end else begin
            sel_wr = 1'b1;
            case (cmd)
              `FCSR_CMD_READ_ARRAY:  sel_src = FCSR_SRC_ARRAY;
              `FCSR_CMD_READ_ID:     sel_src = FCSR_SRC_ID;
              `FCSR_CMD_READ_QUERY:  sel_src = FCSR_SRC_QUERY;
              default:               sel_src = FCSR_SRC_STATUS;
            endcase
            // RQ11 - latch first-cycle block
            s_d.blk = i_addr[AW-1:BLK_LO];
            case (cmd)
              `FCSR_CMD_WORD_PGM_A, `FCSR_CMD_WORD_PGM_B, `FCSR_CMD_BUF_PGM:
                if (s_q.st != FCSR_PGM_SUSP) s_d.st = FCSR_PGM_SETUP;
              `FCSR_CMD_ERASE:
                if (s_q.st == FCSR_PGM_SUSP) s_d.st = FCSR_PGM_SUSP_ERASE_SETUP;
                else if (s_q.st == FCSR_READY) s_d.st = FCSR_ERASE_SETUP;
              `FCSR_CMD_BUFFERED_FACTORY_PROGRAM_MODE:
                if (s_q.st == FCSR_READY) s_d.st = FCSR_BUFFERED_FACTORY_PROGRAM_MODE_SETUP;
              `FCSR_CMD_OTP_SETUP:
                if (s_q.st == FCSR_READY) s_d.st = FCSR_OTP_SETUP;
              `FCSR_CMD_LOCK_SETUP:  s_d.st = FCSR_LOCK_SETUP;
              `FCSR_CMD_CONFIRM:
                if (s_q.st == FCSR_PGM_SUSP) s_d.st = FCSR_PGM_BUSY;
                else if (s_q.st == FCSR_ERASE_SUSP) s_d.st = FCSR_ERASE_BUSY;
              `FCSR_CMD_CLEAR_STATUS: begin
                // RQ6 - clear only when idle
                s_d.err = `FCSR_ERR_RESET;
              end
              default: s_d.st = s_q.st;
            endcase
          end
        end
      endcase
    end
    // A new engine error wins over a simultaneous clear.
    s_d.err = s_d.err | i_err_set;
  end

  always_ff @(posedge i_ref_clk or posedge i_reset) begin
    if (i_reset) begin
      s_q <= '{st: FCSR_READY, blk: '0, busy_part: '0, err: `FCSR_ERR_RESET,
               buffered_factory_program_mode_dat: 1'b0, illegal: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  assign sel.wr   = sel_wr;
  assign sel.part = wpart;
  assign sel.src  = sel_src;

  // ----------------------------------------
  // Read side
  // ----------------------------------------
  fcsr_src_e part_src;
  assign part_src = fcsr_src_e'(sel.sel_flat[2*i_rd_part +: 2]);
  // RQ3 - ID and query locations differ
  always_comb begin
    o_rd_src = part_src;
    if (part_src == FCSR_SRC_ID || part_src == FCSR_SRC_QUERY) begin
      o_rd_src = i_rd_id_loc ? FCSR_SRC_ID : FCSR_SRC_QUERY;
    end
  end
  // RQ2 - busy array read invalid
  assign o_rd_invalid = fcsr_is_busy(s_q.st) && (i_rd_part == s_q.busy_part) &&
                        (part_src == FCSR_SRC_ARRAY);

  assign o_state     = s_q.st;
  assign o_blk_addr  = s_q.blk;
  assign o_err       = s_q.err;
  assign o_busy      = fcsr_is_busy(s_q.st);
  assign o_buffered_factory_program_mode_data = s_q.buffered_factory_program_mode_dat;
  assign o_illegal   = s_q.illegal;
endmodule : fcsr_top

// >>> sim/fcsr_host_model.sv
module fcsr_host_model (
  input  wire logic        i_ref_clk, // Clock.
  output logic             o_wr,      // Write strobe.
  output logic [22:0]      o_addr,    // Write address.
  output logic [15:0]      o_data     // Write data.
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    o_wr = 1'b0;
    o_addr = 23'h00_0000;
    o_data = 16'h0000;
  end
  // same partition address
  // A released bus shows the inverse of the last value, so stale data never looks valid.
  task automatic wr_cmd(input logic [22:0] a, input logic [15:0] d, input int unsigned gap);
    repeat (gap) @(negedge i_ref_clk);
    @(negedge i_ref_clk);
    o_wr = 1'b1;
    o_addr = a;
    o_data = d;
    @(negedge i_ref_clk);
    o_wr = 1'b0;
    o_addr = ~a;
    o_data = ~d;
  endtask : wr_cmd
endmodule : fcsr_host_model

// >>> sim/fcsr_props.sv
`include "fcsr_consts.svh"
module fcsr_props import fcsr_pkg::*; #(
  parameter int PARTS  = 8,
  parameter int AW     = 23,
  parameter int BLK_LO = 16
) (
  input wire logic                 i_ref_clk,    // Clock.
  input wire logic                 i_reset,      // Reset.
  input wire logic                 i_wr,         // Strobe.
  input wire logic [AW-1:0]        i_addr,       // Address.
  input wire logic [15:0]          i_data,       // Data.
  input wire logic                 i_done,       // Done.
  input wire logic [3:0]           i_err_set,    // Error set.
  input wire fcsr_pkg::fcsr_state_e o_state,     // State.
  input wire fcsr_pkg::fcsr_src_e  o_rd_src,     // Read source.
  input wire logic                 o_rd_invalid, // Invalid read.
  input wire logic [AW-1:BLK_LO]   o_blk_addr,   // Block address.
  input wire logic [3:0]           o_err,        // Errors.
  input wire logic                 o_busy,       // Busy.
  input wire logic                 o_buffered_factory_program_mode_data,  // Factory data.
  input wire logic                 o_illegal     // Illegal.
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);
  wire logic [7:0] code = i_data[7:0];
  AST_ILLEGAL: assert property (i_wr && code == 8'h55 && o_state == FCSR_READY |=> o_illegal && o_state == FCSR_READY)
    else $error("illegal code not flagged");
  AST_ILLEGAL_CAUSE: assert property (o_illegal |-> $past(i_wr))
    else $error("illegal pulse without write");
  AST_RD_INVALID: assert property (o_rd_invalid |-> o_busy && o_rd_src == FCSR_SRC_ARRAY)
    else $error("invalid read outside busy array read");
  AST_SUSP_IGNORE: assert property (o_state == FCSR_PGM_SUSP_ERASE_SETUP && i_wr && code == `FCSR_CMD_CONFIRM
    |=> o_state == FCSR_PGM_SUSP)
    else $error("ambiguous confirm not ignored");
  AST_CLR_BUSY: assert property (i_wr && code == `FCSR_CMD_CLEAR_STATUS && o_busy && i_err_set == 4'h0
    |=> $stable(o_err))
    else $error("clear status acted while busy");
  AST_CLR_IDLE: assert property (i_wr && code == `FCSR_CMD_CLEAR_STATUS && o_state == FCSR_READY && i_err_set == 4'h0
    |=> o_err == 4'h0)
    else $error("clear status failed when idle");
  AST_BUFFERED_FACTORY_PROGRAM_MODE: assert property (o_buffered_factory_program_mode_data |-> $past(i_wr) && !$past(i_done))
    else $error("factory data accepted while busy");
  AST_LOCK_READY: assert property (o_state == FCSR_LOCK_SETUP && i_wr && code inside {8'h01, 8'h2F, 8'h03}
    |=> o_state == FCSR_READY)
    else $error("lock confirm did not return ready");
  AST_BLK: assert property (o_state == FCSR_READY && i_wr && code == `FCSR_CMD_ERASE
    |=> o_blk_addr == $past(i_addr[AW-1:BLK_LO]))
    else $error("block address not latched");
  AST_IGNORED: assert property (o_illegal && !$past(i_done) |-> o_state == $past(o_state))
    else $error("illegal cycle changed state");
  COV_ERASE: cover property (o_state == FCSR_ERASE_BUSY && o_busy);
  COV_SUSP: cover property (o_state == FCSR_PGM_SUSP_ERASE_SETUP ##[1:4] o_state == FCSR_PGM_SUSP);
  COV_ILL: cover property (o_illegal);
endmodule : fcsr_props
bind fcsr_top fcsr_props #(.PARTS(PARTS), .AW(AW), .BLK_LO(BLK_LO)) u_props (.i_ref_clk(i_ref_clk),
  .i_reset(i_reset), .i_wr(i_wr), .i_addr(i_addr), .i_data(i_data), .i_done(i_done), .i_err_set(i_err_set),
  .o_state(o_state), .o_rd_src(o_rd_src), .o_rd_invalid(o_rd_invalid), .o_blk_addr(o_blk_addr),
  .o_err(o_err), .o_busy(o_busy), .o_buffered_factory_program_mode_data(o_buffered_factory_program_mode_data), .o_illegal(o_illegal));

// >>> sim/tb.sv
`include "fcsr_consts.svh"
module tb import fcsr_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {fcsr_state_e st; logic [3:0] err; logic cs; fcsr_src_e src; logic cb; logic [6:0] blk;
                  logic [2:0] fl;} fcsr_note_s;
  logic clk = 0, rst = 1, done = 0, id_loc = 0, taken = 0;
  logic [3:0] err_set = 4'h0;
  logic [2:0] rd_part = 3'h0;
  logic [22:0] cur = 23'h00_0000;
  logic [7:0] codes [3] = '{8'h01, 8'h2F, 8'h03};
  wire logic wr, inv, busy, buffered_factory_program_mode, ill;
  wire logic [22:0] addr;
  wire logic [15:0] data;
  wire logic [3:0] err;
  wire logic [22:16] blk;
  fcsr_state_e st;
  fcsr_src_e src;
  fcsr_note_s q [$];
  fcsr_note_s n;
  int failures = 0, comparisons = 0;
  always #2.5 clk = ~clk;
  fcsr_host_model host (.i_ref_clk(clk), .o_wr(wr), .o_addr(addr), .o_data(data));
  fcsr_top DUT (.i_ref_clk(clk), .i_reset(rst), .i_wr(wr), .i_addr(addr), .i_data(data), .i_done(done),
    .i_err_set(err_set), .i_rd_part(rd_part), .i_rd_id_loc(id_loc), .o_state(st), .o_rd_src(src),
    .o_rd_invalid(inv), .o_blk_addr(blk), .o_err(err), .o_busy(busy), .o_buffered_factory_program_mode_data(buffered_factory_program_mode), .o_illegal(ill));
  task automatic results;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results
  task automatic cmd(input logic [7:0] c, input fcsr_state_e s, input logic [3:0] e, input logic cs = 0,
                     input fcsr_src_e sr = FCSR_SRC_ARRAY, input logic cb = 0, input logic [2:0] fl = 3'b000,
                     input logic [7:0] hi = 8'h00);
    q.push_back('{s, e, cs, sr, cb, cur[22:16], fl});
    host.wr_cmd(cur, {hi, c}, $urandom_range(2));
  endtask : cmd
  task automatic fin(input fcsr_state_e s, input logic [3:0] e);
    q.push_back('{s, e, 1'b0, FCSR_SRC_ARRAY, 1'b0, 7'h00, 3'b000});
    @(negedge clk) done = 1'b1;
    @(negedge clk) done = 1'b0;
  endtask : fin
  always @(posedge clk) taken <= wr | done;
  // --------------------------------
  // Result monitor
  // --------------------------------
  always @(negedge clk) begin
    if (taken && q.size() > 0) begin
      n = q.pop_front();
      comparisons++;
      if (!(st === n.st && err === n.err && (!n.cs || src === n.src) && (!n.cb || blk === n.blk) &&
            {ill, buffered_factory_program_mode, inv} === n.fl && busy === (n.st inside {FCSR_PGM_BUSY, FCSR_ERASE_BUSY,
            FCSR_OTP_BUSY, FCSR_BUFFERED_FACTORY_PROGRAM_MODE_SETUP, FCSR_BUFFERED_FACTORY_PROGRAM_MODE_MODE}))) begin
        failures++;
        $display("[FAIL] %0t state %0d err %h src %0d blk %h flags %b", $time, st, err, src, blk, {ill, buffered_factory_program_mode, inv});
      end
    end
  end
  initial begin
    #50us;
    failures++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
  initial begin
    void'($urandom(13));
    repeat (5) @(negedge clk);
    rst = 1'b0;
    cur = 23'($urandom);
    rd_part = cur[22:20];
    id_loc = 1'($urandom);
    cmd(8'h55, FCSR_READY, 4'h0, 0, FCSR_SRC_ARRAY, 0, 3'b100);
    cmd(`FCSR_CMD_ERASE, FCSR_ERASE_SETUP, 4'h0, 1, FCSR_SRC_STATUS, 1);
    cmd(`FCSR_CMD_CONFIRM, FCSR_ERASE_BUSY, 4'h0, 0, FCSR_SRC_ARRAY, 1);
    @(negedge clk) err_set = 4'h5;
    @(negedge clk) err_set = 4'h0;
    cmd(`FCSR_CMD_CLEAR_STATUS, FCSR_ERASE_BUSY, 4'h5);
    fin(FCSR_READY, 4'h5);
    cmd(`FCSR_CMD_CLEAR_STATUS, FCSR_READY, 4'h0);
    $display("test erase and status done");
    cur = 23'($urandom);
    rd_part = cur[22:20];
    cmd(`FCSR_CMD_WORD_PGM_B, FCSR_PGM_SETUP, 4'h0);
    cmd(8'h34, FCSR_PGM_BUSY, 4'h0);
    cmd(`FCSR_CMD_READ_ARRAY, FCSR_PGM_BUSY, 4'h0, 1, FCSR_SRC_ARRAY, 0, 3'b001);
    cmd(`FCSR_CMD_SUSPEND, FCSR_PGM_SUSP, 4'h0);
    cmd(`FCSR_CMD_ERASE, FCSR_PGM_SUSP_ERASE_SETUP, 4'h0);
    cmd(`FCSR_CMD_CONFIRM, FCSR_PGM_SUSP, 4'h0);
    cmd(8'h55, FCSR_PGM_SUSP, 4'h0, 0, FCSR_SRC_ARRAY, 0, 3'b100);
    cmd(`FCSR_CMD_CONFIRM, FCSR_PGM_BUSY, 4'h0);
    fin(FCSR_READY, 4'h0);
    $display("test suspend done");
    foreach (codes[i]) begin
      cmd(`FCSR_CMD_LOCK_SETUP, FCSR_LOCK_SETUP, 4'h0);
      cmd(codes[i], FCSR_READY, 4'h0);
    end
    cmd(`FCSR_CMD_READ_STATUS, FCSR_READY, 4'h0, 1, FCSR_SRC_STATUS);
    cmd(8'h55, FCSR_READY, 4'h0, 1, FCSR_SRC_STATUS, 0, 3'b100);
    cmd(`FCSR_CMD_READ_ARRAY, FCSR_READY, 4'h0, 1, FCSR_SRC_ARRAY);
    cmd(`FCSR_CMD_READ_ID, FCSR_READY, 4'h0, 1, id_loc ? FCSR_SRC_ID : FCSR_SRC_QUERY);
    cmd(`FCSR_CMD_READ_QUERY, FCSR_READY, 4'h0, 1, id_loc ? FCSR_SRC_ID : FCSR_SRC_QUERY);
    $display("test lock and selectors done");
    cmd(`FCSR_CMD_OTP_SETUP, FCSR_OTP_SETUP, 4'h0);
    cmd(8'h21, FCSR_OTP_BUSY, 4'h0);
    fin(FCSR_READY, 4'h0);
    cmd(`FCSR_CMD_BUFFERED_FACTORY_PROGRAM_MODE, FCSR_BUFFERED_FACTORY_PROGRAM_MODE_SETUP, 4'h0, 0, FCSR_SRC_ARRAY, 1);
    fin(FCSR_BUFFERED_FACTORY_PROGRAM_MODE_MODE, 4'h0);
    cmd(8'h12, FCSR_BUFFERED_FACTORY_PROGRAM_MODE_MODE, 4'h0, 0, FCSR_SRC_ARRAY, 0, 3'b010);
    cur = cur ^ 23'h01_0000;
    cmd(8'hFF, FCSR_READY, 4'h0, 0, FCSR_SRC_ARRAY, 0, 3'b000, 8'hFF);
    $display("test otp and factory program done");
    repeat (3) @(negedge clk);
    results();
  end
endmodule : tb
